/* File: design/ifpa_pkg.sv */
// package with constants and types for the flag and priority arbiter
package ifpa_pkg;
   localparam int NUM_PINS      = 6;
   localparam int NUM_PERIPH    = 4;
   localparam int NUM_SRC       = NUM_PINS + NUM_PERIPH;
   localparam int SRC_W         = 4;
   localparam int LVL_W         = 4;
   localparam int REG_W         = 16;
   localparam int ADDR_W        = 4;
   // pin bit positions in the flag and sense registers
   localparam int PIN_BIT [NUM_PINS] = '{7, 6, 5, 4, 1, 0};
   // host register map (word index)
   localparam logic [ADDR_W-1:0] ADDR_FLAGS  = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_SENSE  = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_LVL_LO = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_LVL_MI = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_LVL_HI = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_MASK   = 4'h5;
   localparam logic [ADDR_W-1:0] ADDR_STAT   = 4'h6;
   localparam logic [REG_W-1:0]  FLAG_RESET  = 16'h0000;
   localparam logic [REG_W-1:0]  PIN_MASK    = 16'h00F3;
   localparam logic [LVL_W-1:0]  MASK_RESET  = 4'hF;
   // response budget in states, memory terms added on top
   localparam int EXC_BASE_STATES = 5;
   localparam int TOTAL_PERIPH    = 7;
   localparam int TOTAL_PIN       = 9;
   localparam int ID_PERIPH       = TOTAL_PERIPH - EXC_BASE_STATES;
   localparam int ID_PIN          = TOTAL_PIN - EXC_BASE_STATES;
   localparam int MEM_STATES      = 1;
   localparam int CNT_W           = 4;
   typedef enum logic [2:0] {
      IFPA_IDLE  = 3'b000,
      IFPA_IDENT = 3'b001,
      IFPA_SAVE  = 3'b011,
      IFPA_VECT  = 3'b010,
      IFPA_FETCH = 3'b110
   } ifpa_cpu_state_t;
endpackage

/* File: design/ifpa_if.sv */
// interface between the arbiter and the cpu core
`timescale 1ns/1ps
interface ifpa_if;
   logic                          irq_req;
   logic [ifpa_pkg::LVL_W-1:0]    irq_level;
   logic [ifpa_pkg::SRC_W-1:0]    irq_src;
   logic                          irq_is_pin;
   logic [ifpa_pkg::LVL_W-1:0]    cpu_mask_level;
   logic                          irq_ack;
   logic [ifpa_pkg::SRC_W-1:0]    ack_src;
   modport arb (
      output irq_req, irq_level, irq_src, irq_is_pin,
      input  cpu_mask_level, irq_ack, ack_src
   );
   modport cpu (
      input  irq_req, irq_level, irq_src, irq_is_pin,
      output cpu_mask_level, irq_ack, ack_src
   );
endinterface

/* File: design/ifpa_arbiter.sv */
// interrupt controller end: pin flags, priority pick and mask compare
//
// Overview of operation
// R1 - level mode: high input shows flag 0
// R2 - level mode: low input shows flag 1
// R3 - edge mode: falling edge sets flag
// R4 - edge flag cleared by 0 after read 1
// R5 - edge flag cleared when exception is taken
// R6 - edge request held until accepted
// R7 - power-on reset drops pending edge requests
// R8 - highest programmed level wins
// R9 - ties broken by fixed default order
// R10 - level not above cpu mask ignored
// R11 - level above mask raises cpu request
// R12 - cpu samples request at next decode
// R13 - cpu pushes status word and pc
// R14 - cpu loads accepted level into mask
// R15 - cpu jumps via vector, no delay slot
// R16 - exception to handler fetch: 5 plus memory
// R17 - cpu may finish current sequence first
// R18 - total 7 peripheral, 9 pin, plus memory
// R19 - memory terms: status, pc, vector
// R20 - four-bit levels, zero lowest, fifteen highest
// R21 - sense bit: 0 low level, 1 falling edge
// R22 - pin inputs synchronised before detection
// R23 - new edge beats simultaneous clear
`timescale 1ns/1ps
module ifpa_arbiter #(
   parameter int NP = ifpa_pkg::NUM_PINS,
   parameter int NS = ifpa_pkg::NUM_SRC
) (
   // clock and reset
   input  wire logic                        clk_i,
   input  wire logic                        reset_i,
   // request inputs, pins active low
   input  wire logic [NP-1:0]               pin_n_i,
   input  wire logic [NS-NP-1:0]            periph_req_i,
   // register port
   input  wire logic [ifpa_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [ifpa_pkg::REG_W-1:0]  wdata_i,
   input  wire logic                        wr_i,
   input  wire logic                        rd_i,
   output logic      [ifpa_pkg::REG_W-1:0]  rdata_o,
   // cpu side
   ifpa_if.arb                              cpu
);
   typedef struct packed {
      logic [NP-1:0]                  sync1;
      logic [NP-1:0]                  sync2;
      logic [NP-1:0]                  prev;
      logic [NP-1:0]                  edge_flag;
      logic [NP-1:0]                  read_one;
      logic [NP-1:0]                  sense;
      logic [NS*ifpa_pkg::LVL_W-1:0]  levels;
      logic                           req;
      logic [ifpa_pkg::LVL_W-1:0]     lvl;
      logic [ifpa_pkg::SRC_W-1:0]     src;
      logic                           is_pin;
      logic [ifpa_pkg::REG_W-1:0]     rdata;
   } ifpa_arb_state_t;

   ifpa_arb_state_t st;
   ifpa_arb_state_t next_st;

   // spread pin bits onto their places in a register word
   function automatic logic [ifpa_pkg::REG_W-1:0] to_reg(
      input logic [NP-1:0] v);
      logic [ifpa_pkg::REG_W-1:0] r;
      r = '0;
      for (int i = 0; i < NP; i++) begin
         r[ifpa_pkg::PIN_BIT[i]] = v[i];
      end
      return r;
   endfunction

   // gather pin bits from their places in a register word
   function automatic logic [NP-1:0] from_reg(
      input logic [ifpa_pkg::REG_W-1:0] r);
      logic [NP-1:0] v;
      v = '0;
      for (int i = 0; i < NP; i++) begin
         v[i] = r[ifpa_pkg::PIN_BIT[i]];
      end
      return v;
   endfunction

   // priority field of one source out of the packed level bank
   function automatic logic [ifpa_pkg::LVL_W-1:0] lvl_of(
      input logic [NS*ifpa_pkg::LVL_W-1:0] bank,
      input int                            s);
      return bank[s*ifpa_pkg::LVL_W +: ifpa_pkg::LVL_W];
   endfunction

   // status word: pin kind, request, a fixed one marker and the level
   function automatic logic [ifpa_pkg::REG_W-1:0] status_word(
      input logic                       is_pin,
      input logic                       req,
      input logic [ifpa_pkg::LVL_W-1:0] lvl);
      return {7'h00, is_pin, req, 2'h0, 1'b1, lvl};
   endfunction

   logic [NP-1:0]                 flags;
   logic [NS-1:0]                 active;
   logic [NP-1:0]                 fall;
   logic [NP-1:0]                 wr_clr;
   logic [NP-1:0]                 ack_clr;
   logic [ifpa_pkg::LVL_W-1:0]    best_lvl;
   logic [ifpa_pkg::SRC_W-1:0]    best_src;
   logic                          any;
   logic                          rd_flags;
   logic                          wr_flags;

   always_comb begin
      next_st  = st;
      fall     = st.prev & ~st.sync2;                          // see R3
      wr_clr   = '0;
      ack_clr  = '0;
      rd_flags = rd_i && addr_i == ifpa_pkg::ADDR_FLAGS;
      wr_flags = wr_i && addr_i == ifpa_pkg::ADDR_FLAGS;
      // level mode shows the synchronised pin, edge mode the latch
      for (int i = 0; i < NP; i++) begin
         flags[i] = st.sense[i] ? st.edge_flag[i]
                                : ~st.sync2[i];          // see R1 see R2
         if (cpu.irq_ack && cpu.ack_src == ifpa_pkg::SRC_W'(i)) begin
            ack_clr[i] = 1'b1;                                 // see R5
         end
      end
      if (wr_flags) begin
         wr_clr = ~from_reg(wdata_i) & st.read_one;            // see R4
      end
      // sync chain, first stage read only by the second
      next_st.sync1 = pin_n_i;                                 // see R22
      next_st.sync2 = st.sync1;
      next_st.prev  = st.sync2;
      // set wins over clear; held until acknowledged
      next_st.edge_flag = (st.edge_flag & ~wr_clr & ~ack_clr)
                        | (fall & st.sense);           // see R6 see R23
      // only flags that software has seen set may be cleared by a 0
      if (rd_flags) begin
         next_st.read_one = st.read_one | flags;
      end
      next_st.read_one = next_st.read_one & ~wr_clr;
      if (wr_i) begin
         unique case (addr_i)
            ifpa_pkg::ADDR_SENSE:
               next_st.sense = from_reg(wdata_i);              // see R21
            ifpa_pkg::ADDR_LVL_LO:
               next_st.levels[15:0] = wdata_i;                 // see R20
            ifpa_pkg::ADDR_LVL_MI:
               next_st.levels[31:16] = wdata_i;
            ifpa_pkg::ADDR_LVL_HI:
               next_st.levels[NS*ifpa_pkg::LVL_W-1:32] = wdata_i[7:0];
            default: ;
         endcase
      end
      // arbitration over pin flags then peripheral lines
      active   = {periph_req_i, flags};
      any      = 1'b0;
      best_lvl = '0;
      best_src = '0;
      for (int s = 0; s < NS; s++) begin
         // lower index is higher default priority: strict greater only
         if (active[s] &&                                 // see R8 see R9
             (!any || lvl_of(st.levels, s) > best_lvl)) begin
            any      = 1'b1;
            best_lvl = lvl_of(st.levels, s);
            best_src = ifpa_pkg::SRC_W'(s);
         end
      end
      // dropped the cycle after the ack so one request is never taken twice
      next_st.req    = any && best_lvl > cpu.cpu_mask_level
                       && !cpu.irq_ack;                // see R10 see R11
      next_st.lvl    = best_lvl;
      next_st.src    = best_src;
      next_st.is_pin = best_src < ifpa_pkg::SRC_W'(NP);        // see R18
      // read data stands only in the cycle after the strobe
      next_st.rdata  = '0;
      if (rd_i) begin
         unique case (addr_i)
            ifpa_pkg::ADDR_FLAGS:  next_st.rdata = to_reg(flags);
            ifpa_pkg::ADDR_SENSE:  next_st.rdata = to_reg(st.sense);
            ifpa_pkg::ADDR_LVL_LO: next_st.rdata = st.levels[15:0];
            ifpa_pkg::ADDR_LVL_MI: next_st.rdata = st.levels[31:16];
            ifpa_pkg::ADDR_LVL_HI:
               next_st.rdata = {8'h00, st.levels[NS*ifpa_pkg::LVL_W-1:32]};
            ifpa_pkg::ADDR_STAT:
               next_st.rdata = status_word(st.is_pin, st.req, st.lvl);
            default:               next_st.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         st <= '0;                                             // see R7
         // sync chain resets to the idle pin level: no false edge
         st.sync1 <= '1;
         st.sync2 <= '1;
         st.prev  <= '1;
      end else begin
         st <= next_st;
      end
   end

   assign rdata_o        = st.rdata;
   assign cpu.irq_req    = st.req;
   assign cpu.irq_level  = st.lvl;
   assign cpu.irq_src    = st.src;
   assign cpu.irq_is_pin = st.is_pin;
endmodule

/* File: design/ifpa_cpu.sv */
// cpu core end: takes requests, runs the exception sequence
`timescale 1ns/1ps
module ifpa_cpu #(
   parameter int MEM = ifpa_pkg::MEM_STATES
) (
   // clock and reset
   input  wire logic                       clk_i,
   input  wire logic                       reset_i,
   // user side
   input  wire logic                       decode_i,
   input  wire logic [ifpa_pkg::LVL_W-1:0] mask_wr_i,
   input  wire logic                       mask_we_i,
   output logic      [ifpa_pkg::LVL_W-1:0] mask_o,
   output logic                            busy_o,
   output logic                            vec_fetch_o,
   output logic      [ifpa_pkg::SRC_W-1:0] vec_src_o,
   // arbiter side
   ifpa_if.cpu                             arb
);
   typedef struct packed {
      ifpa_pkg::ifpa_cpu_state_t  fsm;
      logic [ifpa_pkg::CNT_W-1:0] cnt;
      logic [ifpa_pkg::LVL_W-1:0] mask;
      logic [ifpa_pkg::LVL_W-1:0] lvl;
      logic [ifpa_pkg::SRC_W-1:0] src;
      logic                       ack;
      logic                       fetch;
      logic                       busy;
   } ifpa_cpu_st_t;

   ifpa_cpu_st_t st;
   ifpa_cpu_st_t next_st;

   localparam logic [ifpa_pkg::CNT_W-1:0] SAVE_N =
      ifpa_pkg::CNT_W'(ifpa_pkg::EXC_BASE_STATES - 3 + 2 * MEM);
   localparam logic [ifpa_pkg::CNT_W-1:0] VECT_N =
      ifpa_pkg::CNT_W'(1 + MEM);

   always_comb begin
      next_st       = st;
      next_st.ack   = 1'b0;
      next_st.fetch = 1'b0;
      if (mask_we_i && st.fsm == ifpa_pkg::IFPA_IDLE) begin
         next_st.mask = mask_wr_i;
      end
      unique case (st.fsm)
         ifpa_pkg::IFPA_IDLE:
            // taken at decode, after current sequence ends; see R12 see R17
            if (decode_i && arb.irq_req) begin
               next_st.fsm = ifpa_pkg::IFPA_IDENT;
               next_st.lvl = arb.irq_level;
               next_st.src = arb.irq_src;
               next_st.cnt = ifpa_pkg::CNT_W'(arb.irq_is_pin ?
                  ifpa_pkg::ID_PIN - 1 : ifpa_pkg::ID_PERIPH - 1); // see R18
               next_st.ack = 1'b1;
            end
         ifpa_pkg::IFPA_IDENT:
            if (st.cnt == '0) begin
               next_st.fsm = ifpa_pkg::IFPA_SAVE;
               next_st.cnt = SAVE_N;                     // see R13 see R19
            end else begin
               next_st.cnt = st.cnt - 1'b1;
            end
         ifpa_pkg::IFPA_SAVE:
            if (st.cnt == '0) begin
               next_st.fsm  = ifpa_pkg::IFPA_VECT;
               next_st.cnt  = VECT_N;                          // see R16
               next_st.mask = st.lvl;                          // see R14
            end else begin
               next_st.cnt = st.cnt - 1'b1;
            end
         ifpa_pkg::IFPA_VECT:
            if (st.cnt == '0) begin
               next_st.fsm   = ifpa_pkg::IFPA_FETCH;
               next_st.fetch = 1'b1;                           // see R15
            end else begin
               next_st.cnt = st.cnt - 1'b1;
            end
         ifpa_pkg::IFPA_FETCH:
            next_st.fsm = ifpa_pkg::IFPA_IDLE;
         default:
            next_st.fsm = ifpa_pkg::IFPA_IDLE;
      endcase
      next_st.busy = next_st.fsm != ifpa_pkg::IFPA_IDLE;
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         st      <= '0;
         st.mask <= ifpa_pkg::MASK_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign arb.cpu_mask_level = st.mask;
   assign arb.irq_ack        = st.ack;
   assign arb.ack_src        = st.src;
   assign mask_o             = st.mask;
   assign busy_o             = st.busy;
   assign vec_fetch_o        = st.fetch;
   assign vec_src_o          = st.src;
endmodule

/* File: sim/ifpa_properties.sv */
// concurrent checks on the link between arbiter and cpu core
`timescale 1ns/1ps
module ifpa_properties (
   // clock and reset
   input wire logic                       clk_i,
   input wire logic                       reset_i,
   // arbiter to cpu
   input wire logic                       irq_req,
   input wire logic [ifpa_pkg::LVL_W-1:0] irq_level,
   input wire logic [ifpa_pkg::SRC_W-1:0] irq_src,
   input wire logic                       irq_is_pin,
   // cpu to arbiter
   input wire logic [ifpa_pkg::LVL_W-1:0] cpu_mask_level,
   input wire logic                       irq_ack,
   input wire logic [ifpa_pkg::SRC_W-1:0] ack_src
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   logic [3:0] prev_lvl;
   logic [3:0] held_lvl;
   // level of the request that the ack answered
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         prev_lvl <= 4'h0;
         held_lvl <= 4'h0;
      end else begin
         prev_lvl <= irq_level;
         if (irq_ack) begin
            held_lvl <= prev_lvl;
         end
      end
   end
   a_req_above_mask: assert property (irq_req && $stable(cpu_mask_level)
      |-> irq_level > cpu_mask_level) else $error("request not above mask");
   a_ack_after_req: assert property (irq_ack |-> $past(irq_req)
      && ack_src == $past(irq_src)) else $error("ack without request");
   a_ack_drops_req: assert property (irq_ack |=> !irq_req)
      else $error("request stays during ack");
   a_ack_spacing: assert property (irq_ack |=> !irq_ack [*8])
      else $error("ack inside exception sequence");
   a_mask_loaded: assert property (irq_ack |=> ##[1:20]
      cpu_mask_level == held_lvl) else $error("mask not loaded");
   a_level_nonzero: assert property (irq_req |-> irq_level != 4'h0)
      else $error("request at level zero");
   a_pin_kind: assert property (irq_req |-> irq_is_pin == (irq_src < 4'h6))
      else $error("pin flag wrong for source");
   a_src_range: assert property (irq_req |-> irq_src < 4'hA)
      else $error("source out of range");
endmodule

/* File: sim/ifpa_tb_top.sv */
// testbench joining arbiter and cpu core
`timescale 1ns/1ps
module ifpa_tb_top;
   logic        clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic [5:0]  pin_n_i = 6'h3F;
   logic [3:0]  periph_req_i = 4'h0;
   logic [3:0]  addr_i = 4'h0;
   logic [15:0] wdata_i = 16'h0000;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic [15:0] rdata_o;
   logic        decode_i = 1'b1;
   logic [3:0]  mask_wr_i = 4'h0;
   logic        mask_we_i = 1'b0;
   logic [3:0]  mask_o;
   logic        busy_o;
   logic        vec_fetch_o;
   logic [3:0]  vec_src_o;
   logic [15:0] r;
   int          bad_count = 0;
   int          comparisons = 0;
   int          cycles = 0;
   int          n_per;
   int          n_pin;
   localparam int RESP_PER =
      ifpa_pkg::TOTAL_PERIPH + 3 * ifpa_pkg::MEM_STATES;
   ifpa_if u_ifpa_if();
   ifpa_arbiter u_ifpa_arbiter (.clk_i(clk_i), .reset_i(reset_i),
      .pin_n_i(pin_n_i), .periph_req_i(periph_req_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .cpu(u_ifpa_if));
   ifpa_cpu u_ifpa_cpu (.clk_i(clk_i), .reset_i(reset_i),
      .decode_i(decode_i), .mask_wr_i(mask_wr_i), .mask_we_i(mask_we_i),
      .mask_o(mask_o), .busy_o(busy_o), .vec_fetch_o(vec_fetch_o),
      .vec_src_o(vec_src_o), .arb(u_ifpa_if));
   ifpa_properties u_ifpa_properties (.clk_i(clk_i), .reset_i(reset_i),
      .irq_req(u_ifpa_if.irq_req), .irq_level(u_ifpa_if.irq_level),
      .irq_src(u_ifpa_if.irq_src), .irq_is_pin(u_ifpa_if.irq_is_pin),
      .cpu_mask_level(u_ifpa_if.cpu_mask_level),
      .irq_ack(u_ifpa_if.irq_ack), .ack_src(u_ifpa_if.ack_src));
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   task automatic setm(input logic [3:0] l);
      @(posedge clk_i);
      mask_wr_i <= l;
      mask_we_i <= 1'b1;
      @(posedge clk_i);
      mask_we_i <= 1'b0;
   endtask
   // pin 0 low for three cycles, long enough to pass the synchroniser
   task automatic pulse_pin;
      @(posedge clk_i);
      pin_n_i <= 6'h3E;
      repeat (3) @(posedge clk_i);
      pin_n_i <= 6'h3F;
   endtask
   // wait for the ack, then count cycles up to the handler fetch
   task automatic take(input logic [3:0] s, l, output int n);
      for (n = 0; n < 60 && u_ifpa_if.irq_ack !== 1'b1; n++)
         @(posedge clk_i) #1;
      chk("ack seen", 16'(u_ifpa_if.irq_ack), 16'h0001);
      chk("busy in sequence", 16'(busy_o), 16'h0001);
      chk("ack source", 16'(u_ifpa_if.ack_src), 16'(s));
      for (n = 0; n < 60 && vec_fetch_o !== 1'b1; n++)
         @(posedge clk_i) #1;
      chk("fetch seen", 16'(vec_fetch_o), 16'h0001);
      chk("vector source", 16'(vec_src_o), 16'(s));
      chk("mask loaded", 16'(mask_o), 16'(l));
      repeat (4) @(posedge clk_i) #1;
      chk("busy cleared", 16'(busy_o), 16'h0000);
   endtask
   task automatic level_test;
      @(posedge clk_i);
      pin_n_i <= 6'h3E;
      repeat (5) @(posedge clk_i);
      rd(ifpa_pkg::ADDR_FLAGS, r);
      chk("level low flag", r, 16'h0080);
      pin_n_i <= 6'h3F;
      repeat (5) @(posedge clk_i);
      rd(ifpa_pkg::ADDR_FLAGS, r);
      chk("level high flag", r, 16'h0000);
   endtask
   task automatic edge_test;
      wr(ifpa_pkg::ADDR_SENSE, 16'h0080);
      rd(ifpa_pkg::ADDR_SENSE, r);
      chk("sense readback", r, 16'h0080);
      pulse_pin();
      repeat (5) @(posedge clk_i);
      rd(ifpa_pkg::ADDR_FLAGS, r);
      chk("edge flag held", r, 16'h0080);
      wr(ifpa_pkg::ADDR_FLAGS, 16'h0000);
      rd(ifpa_pkg::ADDR_FLAGS, r);
      chk("edge flag cleared", r, 16'h0000);
   endtask
   task automatic arb_test;
      periph_req_i <= 4'h7;
      wr(ifpa_pkg::ADDR_LVL_MI, 16'h5555);
      wr(ifpa_pkg::ADDR_LVL_HI, 16'h0077);
      rd(ifpa_pkg::ADDR_LVL_HI, r);
      chk("level readback", r, 16'h0077);
      setm(4'h7);
      repeat (8) @(posedge clk_i);
      chk("equal level ignored", 16'(u_ifpa_if.irq_req), 16'h0000);
      rd(ifpa_pkg::ADDR_STAT, r);
      chk("status below mask", r, 16'h0017);
      setm(4'h4);
      take(4'h8, 4'h7, n_per);
      chk("periph time", 16'(n_per), 16'(RESP_PER));
      periph_req_i <= 4'h3;
      decode_i <= 1'b0;
      setm(4'h4);
      repeat (4) @(posedge clk_i) #1;
      chk("request raised", 16'(u_ifpa_if.irq_req), 16'h0001);
      chk("no take off decode", 16'(busy_o), 16'h0000);
      @(posedge clk_i);
      decode_i <= 1'b1;
      take(4'h6, 4'h5, n_per);
      periph_req_i <= 4'h0;
   endtask
   // a pin request needs two more identification states
   task automatic pin_test;
      wr(ifpa_pkg::ADDR_LVL_LO, 16'h9999);
      setm(4'h4);
      pulse_pin();
      take(4'h0, 4'h9, n_pin);
      chk("pin response", 16'(n_pin), 16'(n_per + 2));
      rd(ifpa_pkg::ADDR_FLAGS, r);
      chk("flag cleared on accept", r, 16'h0000);
   endtask
   // a pending edge request must not survive a reset in mid-run
   task automatic reset_test;
      pulse_pin();
      repeat (3) @(posedge clk_i);
      rd(ifpa_pkg::ADDR_FLAGS, r);
      chk("pending below mask", r, 16'h0080);
      @(posedge clk_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      rd(ifpa_pkg::ADDR_FLAGS, r);
      chk("pending dropped", r, ifpa_pkg::FLAG_RESET);
      rd(ifpa_pkg::ADDR_SENSE, r);
      chk("sense after reset", r, 16'h0000);
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 6000) begin
         bad_count++;
         conclude();
      end
   end
   initial begin
      repeat (4) @(posedge clk_i);
      reset_i <= 1'b0;
      rd(ifpa_pkg::ADDR_FLAGS, r);
      chk("flags at reset", r, ifpa_pkg::FLAG_RESET);
      rd(4'hF, r);
      chk("unmapped read", r, 16'h0000);
      chk("mask at reset", 16'(mask_o), 16'(ifpa_pkg::MASK_RESET));
      level_test();
      edge_test();
      arb_test();
      pin_test();
      reset_test();
      conclude();
   end
endmodule
